// [src/display_supply_i2c_registers.sv]
/*
  Byte-wide register bank of a display supply, reached as a two-wire
  serial slave, with regulator gating and latched fault flags.
  Assumes SCL/SDA and enable pins are asynchronous to mclk, and that
  mclk is far faster than the serial clock. rst_b is the supply power-on.
*/
// Functional notes
// R01: master writes: start, addr+0, pointer, data, stop
// R02: acknowledge every valid received byte
// R03: commit on stop after acked byte only
// R04: read: pointer write, restart, addr+1, data
// R05: slave drives data; master ends with nack
// R06: registers 8 bits, captured at eighth bit
// R07: reset loads documented defaults
// R08: master avoids reserved values and pointers
// R09: only power cycle restores all defaults
// R10: enable register bits and defaults
// R11: three 5-bit voltage trim codes
// R12: software keeps trims within voltage limits
// R13: no trim change during soft start
// R14: boost and pump control registers
// R15: fault register bits and default
// R16: enable pin cycle clears fault bits
// R17: over-temperature clears on second read
// R18: respond only to slave address
// R19: unused bits stored but without effect
// R20: regulator runs need bit and pin
// R21: writes to fault register ignored
`timescale 1ns/1ps
`default_nettype none

module display_supply_i2c_registers (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      negative_enable_pin,
  input  wire logic                      positive_enable_pin,
  input  wire supply_pkg::fault_in_t     fault_detect,
  output supply_pkg::reg_run_t           regulator_run,
  output logic [supply_pkg::TRIM_W-1:0]  boost_voltage_trim,
  output logic [supply_pkg::TRIM_W-1:0]  negative_rail_trim,
  output logic [supply_pkg::TRIM_W-1:0]  positive_rail_trim,
  output logic [7:0]                     boost_control,
  output logic [7:0]                     charge_pump_control
);

  typedef struct packed {
    supply_pkg::link_state_t state;
    supply_pkg::byte_phase_t phase;
    logic [3:0]              bits;
    logic [7:0]              shift;
    logic                    rw;
    logic [7:0]              ptr;
    logic [7:0]              stage;
    logic                    wr_valid;
    logic                    sda_oe;
    logic [7:0]              enable;
    logic [7:0]              boost_trim;
    logic [7:0]              neg_trim;
    logic [7:0]              pos_trim;
    logic [7:0]              boost_ctrl;
    logic [7:0]              pump_ctrl;
    logic [3:0]              fault;
    logic                    otp_read_once;
    logic                    pins_armed;
    supply_pkg::reg_run_t    run;
  } main_st_t;

  // R07: power-on defaults
  localparam main_st_t ST_RST = '{
    state:      supply_pkg::S_IDLE,
    phase:      supply_pkg::P_ADDR,
    enable:     supply_pkg::ENABLE_RST,
    boost_trim: supply_pkg::BOOST_TRIM_RST,
    neg_trim:   supply_pkg::NEG_TRIM_RST,
    pos_trim:   supply_pkg::POS_TRIM_RST,
    boost_ctrl: supply_pkg::BOOST_CTRL_RST,
    pump_ctrl:  supply_pkg::PUMP_CTRL_RST,
    fault:      supply_pkg::FAULT_RST,
    default:    '0
  };

  main_st_t                st;
  main_st_t                next_st;
  supply_pkg::pin_bundle_t pins;
  supply_pkg::bus_evt_t    evt;
  logic                    fault_read;
  logic [7:0]              rd_byte;
  logic [47:0]             cfg_bank;

  pin_sync #(
    .WIDTH   (8),
    .RST_VAL (supply_pkg::PIN_IDLE)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in ({scl, sda_in, negative_enable_pin, positive_enable_pin,
                fault_detect}),
    .sync_out (pins)
  );

  bus_event_detect u_bus_event_detect (
    .mclk  (mclk),
    .rst_b (rst_b),
    .scl   (pins.scl),
    .sda   (pins.sda),
    .evt   (evt)
  );

  // R15: upper four bits read as zero
  function automatic logic [7:0] read_reg(input main_st_t s);
    case (s.ptr)
      supply_pkg::FAULT_PTR:      read_reg = {4'h0, s.fault};
      supply_pkg::ENABLE_PTR:     read_reg = s.enable;
      supply_pkg::BOOST_TRIM_PTR: read_reg = s.boost_trim;
      supply_pkg::NEG_TRIM_PTR:   read_reg = s.neg_trim;
      supply_pkg::POS_TRIM_PTR:   read_reg = s.pos_trim;
      supply_pkg::BOOST_CTRL_PTR: read_reg = s.boost_ctrl;
      supply_pkg::PUMP_CTRL_PTR:  read_reg = s.pump_ctrl;
      default:                    read_reg = supply_pkg::UNMAPPED_READ;
    endcase
  endfunction : read_reg

  assign rd_byte  = read_reg(st);
  assign cfg_bank = {st.enable, st.boost_trim, st.neg_trim, st.pos_trim,
                     st.boost_ctrl, st.pump_ctrl};

  always_comb
  begin
    next_st    = st;
    fault_read = 1'b0;
    unique case (st.state)
      supply_pkg::S_IDLE:
        next_st.sda_oe = 1'b0;
      supply_pkg::S_RX:
      begin
        if (evt.scl_rise && st.bits < supply_pkg::BYTE_BITS)
        begin
          next_st.shift = {st.shift[6:0], evt.sda};
          next_st.bits  = st.bits + 4'h1;
          // R06: latch data at its last bit
          if (st.phase == supply_pkg::P_DATA && st.bits == 4'h7)
            next_st.stage = {st.shift[6:0], evt.sda};
        end
        else if (evt.scl_fall && st.bits == supply_pkg::BYTE_BITS)
        begin
          next_st.bits   = '0;
          next_st.state  = supply_pkg::S_RX_ACK;
          // R02: pull data low through ninth clock
          next_st.sda_oe = 1'b1;
          unique case (st.phase)
            supply_pkg::P_ADDR:
            begin
              // R18: foreign address waits for next start
              if (st.shift[7:1] != supply_pkg::SLAVE_ADDR)
              begin
                next_st.state  = supply_pkg::S_IDLE;
                next_st.sda_oe = 1'b0;
              end
              next_st.rw = st.shift[0];
            end
            supply_pkg::P_PTR:
              next_st.ptr = st.shift;
            supply_pkg::P_DATA:
              next_st.ptr = st.ptr;
            // extra bytes beyond one data byte get no ack
            supply_pkg::P_DONE:
              next_st.sda_oe = 1'b0;
          endcase
        end
      end
      supply_pkg::S_RX_ACK:
      begin
        // R03: data byte counts once its ack is clocked
        if (evt.scl_rise && st.phase == supply_pkg::P_DATA && st.sda_oe)
          next_st.wr_valid = 1'b1;
        if (evt.scl_fall)
        begin
          next_st.sda_oe = 1'b0;
          next_st.state  = supply_pkg::S_RX;
          unique case (st.phase)
            supply_pkg::P_ADDR:
            begin
              next_st.phase = supply_pkg::P_PTR;
              // R04: read address returns the held pointer
              if (st.rw)
              begin
                next_st.state  = supply_pkg::S_TX;
                next_st.shift  = rd_byte;
                next_st.sda_oe = !rd_byte[7];
              end
            end
            supply_pkg::P_PTR:  next_st.phase = supply_pkg::P_DATA;
            supply_pkg::P_DATA: next_st.phase = supply_pkg::P_DONE;
            supply_pkg::P_DONE: next_st.phase = supply_pkg::P_DONE;
          endcase
        end
      end
      supply_pkg::S_TX:
      begin
        if (evt.scl_fall)
        begin
          next_st.bits = st.bits + 4'h1;
          if (st.bits == supply_pkg::LAST_TX_BIT)
          begin
            next_st.bits   = '0;
            next_st.state  = supply_pkg::S_TX_ACK;
            next_st.sda_oe = 1'b0;
            fault_read     = (st.ptr == supply_pkg::FAULT_PTR);
          end
          else
          begin
            // R05: open-drain, so only zeros are driven
            next_st.shift  = {st.shift[6:0], 1'b0};
            next_st.sda_oe = !st.shift[6];
          end
        end
      end
      supply_pkg::S_TX_ACK:
      begin
        // R05: master nack ends the read
        if (evt.scl_rise && evt.sda)
          next_st.state = supply_pkg::S_IDLE;
        else if (evt.scl_fall)
        begin
          // no auto-increment: an acked read repeats the same register
          next_st.state  = supply_pkg::S_TX;
          next_st.shift  = rd_byte;
          next_st.sda_oe = !rd_byte[7];
        end
      end
      default:
      begin
        next_st.state  = supply_pkg::S_IDLE;
        next_st.sda_oe = 1'b0;
      end
    endcase

    if (evt.start)
    begin
      next_st.state    = supply_pkg::S_RX;
      next_st.phase    = supply_pkg::P_ADDR;
      next_st.bits     = '0;
      next_st.sda_oe   = 1'b0;
      next_st.wr_valid = 1'b0;
    end

    if (evt.stop)
    begin
      next_st.state    = supply_pkg::S_IDLE;
      next_st.sda_oe   = 1'b0;
      next_st.wr_valid = 1'b0;
      // R03: stop before the data byte is acked leaves wr_valid clear
      if (st.wr_valid)
      begin
        // R19: full byte kept, unused bits included
        case (st.ptr)
          supply_pkg::ENABLE_PTR:     next_st.enable     = st.stage;
          supply_pkg::BOOST_TRIM_PTR: next_st.boost_trim = st.stage;
          supply_pkg::NEG_TRIM_PTR:   next_st.neg_trim   = st.stage;
          supply_pkg::POS_TRIM_PTR:   next_st.pos_trim   = st.stage;
          supply_pkg::BOOST_CTRL_PTR: next_st.boost_ctrl = st.stage;
          supply_pkg::PUMP_CTRL_PTR:  next_st.pump_ctrl  = st.stage;
          // R21: fault register and unlisted pointers absorb writes
          default:                    next_st.ptr        = st.ptr;
        endcase
      end
    end

    // R16: both pins low together, then high together
    if (!pins.neg_en && !pins.pos_en)
      next_st.pins_armed = 1'b1;
    else if (pins.neg_en && pins.pos_en && st.pins_armed)
    begin
      next_st.pins_armed    = 1'b0;
      next_st.fault         = '0;
      next_st.otp_read_once = 1'b0;
    end

    // R17: first read reports, second clears only the temperature flag
    if (fault_read && st.fault[supply_pkg::FAULT_OTP_BIT])
    begin
      next_st.otp_read_once = !st.otp_read_once;
      if (st.otp_read_once)
        next_st.fault[supply_pkg::FAULT_OTP_BIT] = 1'b0;
    end

    // R15: a live fault wins over any clear in the same cycle
    next_st.fault = next_st.fault | pins.fault;

    // R20: each regulator needs its bit and its pin condition
    next_st.run.boost_run = st.enable[supply_pkg::EN_BOOST_BIT]
                            && (pins.neg_en || pins.pos_en);
    next_st.run.pump_run  = st.enable[supply_pkg::EN_PUMP_BIT]
                            && pins.neg_en;
    next_st.run.ldo_run   = st.enable[supply_pkg::EN_LDO_BIT]
                            && pins.pos_en;
    // R10: pull-down active while its bit is clear
    next_st.run.pos_pulldown_en = !st.enable[supply_pkg::EN_PULLDOWN_BIT];
  end

  // R09: no register path resets the bank, only rst_b
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= ST_RST;
    else
      st <= next_st;
  end

  assign sda_out             = 1'b0;
  assign sda_oe              = st.sda_oe;
  assign regulator_run       = st.run;
  // R11: five-bit trim codes
  assign boost_voltage_trim  = st.boost_trim[supply_pkg::TRIM_W-1:0];
  assign negative_rail_trim  = st.neg_trim[supply_pkg::TRIM_W-1:0];
  assign positive_rail_trim  = st.pos_trim[supply_pkg::TRIM_W-1:0];
  // R14: control bytes passed whole to the regulators
  assign boost_control       = st.boost_ctrl;
  assign charge_pump_control = st.pump_ctrl;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_addr_ack : // R02
  assert property (st.state == supply_pkg::S_RX && evt.scl_fall
    && st.phase == supply_pkg::P_ADDR && st.bits == supply_pkg::BYTE_BITS
    && st.shift[7:1] == supply_pkg::SLAVE_ADDR
    |=> st.state == supply_pkg::S_RX_ACK && st.sda_oe)
  else $error("own address not acknowledged");

  chk_addr_ignore : // R18
  assert property (st.state == supply_pkg::S_RX && evt.scl_fall
    && st.phase == supply_pkg::P_ADDR && st.bits == supply_pkg::BYTE_BITS
    && st.shift[7:1] != supply_pkg::SLAVE_ADDR
    |=> st.state == supply_pkg::S_IDLE && !st.sda_oe)
  else $error("foreign address answered");

  chk_stop_commit : // R03
  assert property (evt.stop && st.wr_valid
    && st.ptr == supply_pkg::ENABLE_PTR
    |=> st.enable == $past(st.stage))
  else $error("write not committed at stop");

  chk_partial_drop : // R03
  assert property (evt.stop && !st.wr_valid |=> $stable(cfg_bank))
  else $error("partial write changed a register");

  chk_fault_ro_write : // R21
  assert property (evt.stop && st.wr_valid
    && st.ptr == supply_pkg::FAULT_PTR && !st.pins_armed
    |=> st.fault == ($past(st.fault) | $past(pins.fault)))
  else $error("fault register altered by write");

  chk_reset_values : // R07
  assert property (@(posedge mclk) $rose(rst_b) |-> st.enable == 8'h07
    && st.boost_ctrl == 8'h34 && st.pump_ctrl == 8'hDA
    && st.fault == 4'h0 && st.pos_trim == 8'h00)
  else $error("defaults not loaded at reset");

  chk_enable_cycle : // R16
  assert property (st.pins_armed && pins.neg_en && pins.pos_en
    && pins.fault == 4'h0 |=> st.fault == 4'h0)
  else $error("enable pin cycle did not clear faults");

  chk_otp_clear : // R17
  assert property (st.state == supply_pkg::S_TX && evt.scl_fall
    && st.bits == 4'h7 && st.ptr == supply_pkg::FAULT_PTR
    && st.otp_read_once && st.fault[0] && pins.fault == 4'h0
    && !st.pins_armed
    |=> !st.fault[0] && st.fault[3:1] == $past(st.fault[3:1]))
  else $error("second fault read did not clear temperature flag");

  chk_run_gate : // R20
  assert property (!pins.neg_en && !pins.pos_en [*2]
    |-> !st.run.boost_run && !st.run.pump_run && !st.run.ldo_run)
  else $error("regulator running with enable pins low");

  chk_tx_drive : // R05
  assert property (st.state == supply_pkg::S_TX
    |-> st.sda_oe == !st.shift[7])
  else $error("data pin does not follow transmitted bit");

  chk_read_nack : // R05
  assert property (st.state == supply_pkg::S_TX_ACK && evt.scl_rise
    && evt.sda |=> st.state == supply_pkg::S_IDLE)
  else $error("read not ended by master nack");

  cov_write_commit : cover property (evt.stop && st.wr_valid);
  cov_read_nack : cover property (st.state == supply_pkg::S_TX_ACK
    && evt.scl_rise && evt.sda);
  cov_otp_clear : cover property (fault_read && st.otp_read_once
    && st.fault[0]);
  cov_pin_clear : cover property (st.pins_armed && pins.neg_en
    && pins.pos_en && st.fault != 4'h0);

endmodule : display_supply_i2c_registers

`default_nettype wire

// [src/supply_pkg.sv]
/*
  Shared constants and carrier types for the display supply register bank:
  pointer map, reset values, field positions, link states and pin bundles.
  Assumes a single 8-bit pointer space reached over a two-wire serial link.
*/
package supply_pkg;

  localparam logic [6:0] SLAVE_ADDR     = 7'h29;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] LAST_TX_BIT    = 4'h7;
  localparam int         TRIM_W         = 5;

  localparam logic [7:0] FAULT_PTR      = 8'h04;
  localparam logic [7:0] ENABLE_PTR     = 8'h05;
  localparam logic [7:0] BOOST_TRIM_PTR = 8'h06;
  localparam logic [7:0] NEG_TRIM_PTR   = 8'h08;
  localparam logic [7:0] POS_TRIM_PTR   = 8'h09;
  localparam logic [7:0] BOOST_CTRL_PTR = 8'h0D;
  localparam logic [7:0] PUMP_CTRL_PTR  = 8'h0F;

  localparam logic [3:0] FAULT_RST      = 4'h0;
  localparam logic [7:0] ENABLE_RST     = 8'h07;
  localparam logic [7:0] BOOST_TRIM_RST = 8'h00;
  localparam logic [7:0] NEG_TRIM_RST   = 8'h00;
  localparam logic [7:0] POS_TRIM_RST   = 8'h00;
  localparam logic [7:0] BOOST_CTRL_RST = 8'h34;
  localparam logic [7:0] PUMP_CTRL_RST  = 8'hDA;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  localparam int EN_BOOST_BIT    = 0;
  localparam int EN_PUMP_BIT     = 1;
  localparam int EN_LDO_BIT      = 2;
  localparam int EN_PULLDOWN_BIT = 6;
  localparam int FAULT_OTP_BIT   = 0;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_RX     = 3'b001,
    S_RX_ACK = 3'b011,
    S_TX     = 3'b010,
    S_TX_ACK = 3'b110
  } link_state_t;

  typedef enum logic [1:0] {
    P_ADDR = 2'b00,
    P_PTR  = 2'b01,
    P_DATA = 2'b11,
    P_DONE = 2'b10
  } byte_phase_t;

  // bit order matches the fault register, bit 3 down to bit 0
  typedef struct packed {
    logic pos_uv;
    logic neg_uv;
    logic boost_uv;
    logic over_temp;
  } fault_in_t;

  typedef struct packed {
    logic      scl;
    logic      sda;
    logic      neg_en;
    logic      pos_en;
    fault_in_t fault;
  } pin_bundle_t;

  // idle bus lines are high, everything else low
  localparam logic [7:0] PIN_IDLE = 8'hC0;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_evt_t;

  typedef struct packed {
    logic boost_run;
    logic pump_run;
    logic ldo_run;
    logic pos_pulldown_en;
  } reg_run_t;

endpackage : supply_pkg

// [src/pin_sync.sv]
/*
  Two-stage synchroniser for a bundle of asynchronous pins.
  Assumes each bit is an independent level; no word coherence is implied.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  always_comb
  begin
    next_st.meta = async_in;
    next_st.sync = st.meta;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '{meta: RST_VAL, sync: RST_VAL};
    else
      st <= next_st;
  end

  assign sync_out = st.sync;

endmodule : pin_sync

`default_nettype wire

// [src/bus_event_detect.sv]
/*
  Finds clock edges and start/stop conditions on the synchronised
  two-wire bus lines. Assumes both inputs are already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_event_detect (
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic           scl,
  input  wire logic           sda,
  output supply_pkg::bus_evt_t evt
);

  typedef struct packed {
    logic                 scl_q;
    logic                 sda_q;
    supply_pkg::bus_evt_t evt;
  } det_st_t;

  det_st_t st;
  det_st_t next_st;

  always_comb
  begin
    next_st.scl_q        = scl;
    next_st.sda_q        = sda;
    // data may only move with the clock high for start and stop
    next_st.evt.start    = scl && st.scl_q && st.sda_q && !sda;
    next_st.evt.stop     = scl && st.scl_q && !st.sda_q && sda;
    next_st.evt.scl_rise = scl && !st.scl_q;
    next_st.evt.scl_fall = !scl && st.scl_q;
    next_st.evt.sda      = sda;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '{scl_q: 1'b1, sda_q: 1'b1, evt: 5'h01};
    else
      st <= next_st;
  end

  assign evt = st.evt;

endmodule : bus_event_detect

`default_nettype wire

// [testbench/i2c_master_model.sv]
/*
  Behavioural two-wire bus master for the supply register bank bench.
  Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // quarter of the 80 ns serial period
  localparam time Q = 20ns;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic r);
    #Q sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask : bit_io

  // also serves as repeated start when scl is low
  task automatic start();
    #Q sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
  endtask : start

  // scl stands still high after the frame
  task automatic stop();
    #Q sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop

  // msb first then released ack clock
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : recv_byte
endmodule : i2c_master_model
`default_nettype wire

// [testbench/test_display_supply_i2c_registers.sv]
/*
  Self-checking bench for the supply register bank.
  Assumes a 125 MHz mclk and the bus master model on the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none

module test_display_supply_i2c_registers;
  logic                  mclk, rst_b, scl, sda_drv, sda_out, sda_oe;
  logic                  nen, pen, a;
  wire logic             sda;
  supply_pkg::fault_in_t fault_detect;
  supply_pkg::reg_run_t  run;
  logic [4:0]            bt, nt, pt;
  logic [7:0]            bc, pc, d, lfsr;
  logic [7:0]            mdl [7];
  int                    errors, cmp_count;
  localparam logic [7:0] PTRS [7] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09,
                                      8'h0D, 8'h0F};

  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
  always #4 mclk = ~mclk;

  i2c_master_model u_mst (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  display_supply_i2c_registers u_dut (
    .mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .negative_enable_pin(nen),
    .positive_enable_pin(pen), .fault_detect(fault_detect),
    .regulator_run(run), .boost_voltage_trim(bt), .negative_rail_trim(nt),
    .positive_rail_trim(pt), .boost_control(bc), .charge_pump_control(pc));

  task automatic finish_test();
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  // reserved bits fixed; trims kept under voltage limits
  function automatic logic [7:0] legal(input int i, input logic [7:0] v);
    case (i)
      1: return v & 8'h7F;
      2: return {v[7:5], 5'(v[4:0] % 18)};
      3, 4: return {v[7:5], 5'(v[4:0] % 15)};
      5: return {2'b00, v[5:0]};
      default: return {2'b11, v[5:0]};
    endcase
  endfunction : legal

  task automatic wr(input logic [7:0] adr, ptr, dat, output logic ack);
    logic a1, a2;
    // serial edges kept clear of the mclk sampling edge
    @(posedge mclk);
    #1;
    u_mst.start();
    u_mst.send_byte(adr, ack);
    u_mst.send_byte(ptr, a1);
    u_mst.send_byte(dat, a2);
    u_mst.stop();
    ack = ack & a1 & a2;
    repeat (8) @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
    logic a0, a1, a2;
    // serial edges kept clear of the mclk sampling edge
    @(posedge mclk);
    #1;
    u_mst.start();
    u_mst.send_byte(8'h52, a0);
    u_mst.send_byte(ptr, a1);
    u_mst.start();
    u_mst.send_byte(8'h53, a2);
    u_mst.recv_byte(v, 1'b0);
    u_mst.stop();
    check("read_ack", {5'h00, a0, a1, a2}, 8'h07);
    repeat (8) @(posedge mclk);
  endtask : rd

  task automatic check_defaults();
    mdl = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h34, 8'hDA};
    check("boost_control", bc, 8'h34);
    check("charge_pump_control", pc, 8'hDA);
    for (int i = 0; i < 7; i++)
    begin
      rd(PTRS[i], d);
      check("default", d, mdl[i]);
    end
  endtask : check_defaults

  initial
  begin
    #600us;
    errors++;
    finish_test();
  end

  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {nen, pen} = 2'b11;
    fault_detect = '0;
    errors = 0;
    cmp_count = 0;
    lfsr = 8'h5B;
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge mclk);
    check_defaults();
    rd(8'h07, d);
    check("unmapped", d, 8'h00);
    for (int n = 0; n < 14; n++)
    begin
      int i;
      i = 1 + rnd() % 6;
      @(posedge mclk);
      #1 {nen, pen} = 2'(rnd() % 4);
      // no trim write while a rail soft-starts
      repeat (16) @(posedge mclk);
      mdl[i] = legal(i, rnd());
      wr(8'h52, PTRS[i], mdl[i], a);
      check("write_ack", a, 1'b1);
      rd(PTRS[i], d);
      check("readback", d, mdl[i]);
      check("boost_trim", bt, mdl[2][4:0]);
      check("neg_trim", nt, mdl[3][4:0]);
      check("pos_trim", pt, mdl[4][4:0]);
      check("boost_control", bc, mdl[5]);
      check("charge_pump_control", pc, mdl[6]);
      check("run", run, {mdl[1][0] & (nen | pen), mdl[1][1] & nen,
                          mdl[1][2] & pen, ~mdl[1][6]});
    end
    // pins high and disarmed so the fault write check can fire
    #1 {nen, pen} = 2'b11;
    wr(8'h54, 8'h06, ~mdl[2], a);
    check("foreign_ack", a, 1'b0);
    rd(8'h06, d);
    check("foreign_ignored", d, mdl[2]);
    @(posedge mclk);
    #1 u_mst.start();
    u_mst.send_byte(8'h52, a);
    u_mst.send_byte(8'h06, a);
    for (int k = 0; k < 4; k++)
      u_mst.bit_io(~mdl[2][7 - k], a);
    u_mst.stop();
    rd(8'h06, d);
    check("partial_dropped", d, mdl[2]);
    wr(8'h52, 8'h04, 8'h0F, a);
    check("fault_write_ack", a, 1'b1);
    rd(8'h04, d);
    check("fault_ro", d, 8'h00);
    @(posedge mclk);
    #1 {nen, pen} = 2'b11;
    fault_detect = 4'hF;
    repeat (4) @(posedge mclk);
    #1 fault_detect = 4'h0;
    rd(8'h04, d);
    check("fault_first", d, 8'h0F);
    rd(8'h04, d);
    check("fault_second", d, 8'h0F);
    rd(8'h04, d);
    check("fault_otp_cleared", d, 8'h0E);
    #1 {nen, pen} = 2'b00;
    repeat (8) @(posedge mclk);
    #1 {nen, pen} = 2'b11;
    repeat (8) @(posedge mclk);
    rd(8'h04, d);
    check("fault_pin_clear", d, 8'h00);
    #1 rst_b = 1'b0;
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge mclk);
    // only the supply cycle restores defaults
    check_defaults();
    finish_test();
  end
endmodule : test_display_supply_i2c_registers
`default_nettype wire
